// ### logic/pbc_core.sv
// Calibration and control logic of a fractional-N synthesizer.
// Assumes the analog loop reports comparator results on plain pins that are
// asynchronous to ref_clk; ref_clk stands for the phase detector clock.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - Rising enable pin or re-lock bit write starts VCO and band search.
// - Search picks one of three VCOs and 128 bands from active bank.
// - Locking starts only after VCO and band choice are complete.
// - Band code readable; code 127 or 0 sets the failure flag.
// - Band code 1 to 126 means coarse search succeeded.
// - LO divider ratios 1 to 32; quadrature stage divides by two more.
// - Bank select low uses bank A, high uses bank B.
// - Fraction resolves with 24-bit denominator, LO divider and two.
// - Prescaler then fractional divider driven by sequence generator.
// - Aux output four may show lock; lock also readable.
// - Lock flag high only while tuning voltage is inside window.
// - State machine runs on the phase detector clock.
// - Re-lock sequence completes quickly at fast detector clocks.
// - Each bank has 6-bit pump current, default 31, maximum 63.
// - Bandwidth calibration sets pump current from measured VCO gain.
// - Clearing keepalive powers down reference circuits while idle.
// - Cold start or keepalive clear waits warm-up count before enable.
// - With keepalive set, enable locking starts without warm-up.
// - Low hard reset returns all logic to startup state.
module pbc_core import pbc_pkg::*; #(
  parameter int BAND_W = 7,
  parameter int SETTLE_CYCLES = PBC_SETTLE_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hard_reset_n,
  input wire logic enable_pin,
  input wire logic bank_select,
  input wire logic [1:0] vco_too_fast,
  input wire logic tune_in_window,
  input wire logic [5:0] measured_pump,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] vco_select,
  output logic [BAND_W-1:0] band_code,
  output logic [PBC_FRAC_W-1:0] frac_word,
  output logic [4:0] local_osc_divider,
  output logic [2:0] ref_divider,
  output logic [PBC_CP_W-1:0] pump_current,
  output logic ref_power_on,
  output logic loop_enable,
  output logic aux_out_four
);
  // Remap vco_too_fast: bit0 is the band comparator, bit1 the VCO range check.
  logic rst;
  logic [1:0] hard_sync_reg;
  logic [31:0] bank_a_settings_reg, bank_b_settings_reg;
  logic [5:0] bank_a_pump_current_reg, bank_b_pump_current_reg;
  logic relock_reg, keepalive_reg, bwcal_reg, aux_lock_reg, aux_level_reg;
  logic [7:0] ref_warmup_count_reg;
  logic [2:0] en_sync_reg, bank_sync_reg, lock_sync_reg, cmp_sync_reg, rng_sync_reg;
  pbc_state_t state_reg, state_next;
  logic [1:0] vco_reg;
  logic [6:0] band_reg, step_reg;
  logic [2:0] steps_left_reg;
  logic [15:0] settle_reg;
  logic [7:0] warm_reg;
  logic band_search_fail_flag_reg, lock_reg, bank_reg;
  logic [31:0] rdata_reg;
  logic ready_reg, err_reg;
  logic [31:0] out_frac_reg;
  logic [5:0] out_pump_reg;

  // Hard reset pin passes two flops before it joins system reset.
  // The pin is asynchronous to ref_clk; fed straight into every flop, its release
  // could be seen on different edges by different parts of the block.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hard_sync_reg <= 2'b11;
    end else begin
      hard_sync_reg <= {hard_sync_reg[0], hard_reset_n};
    end
  end

  assign rst = sys_rst | ~hard_sync_reg[1];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_sync_reg <= 3'h0;
      bank_sync_reg <= 3'h0;
      lock_sync_reg <= 3'h0;
      cmp_sync_reg <= 3'h0;
      rng_sync_reg <= 3'h0;
    end else begin
      en_sync_reg <= {en_sync_reg[1:0], enable_pin};
      bank_sync_reg <= {bank_sync_reg[1:0], bank_select};
      lock_sync_reg <= {lock_sync_reg[1:0], tune_in_window};
      cmp_sync_reg <= {cmp_sync_reg[1:0], vco_too_fast[0]};
      rng_sync_reg <= {rng_sync_reg[1:0], vco_too_fast[1]};
    end
  end

  wire en_now = en_sync_reg[1];
  wire en_rise = en_sync_reg[1] & ~en_sync_reg[2];
  wire cmp_fast = cmp_sync_reg[1];
  wire rng_fast = rng_sync_reg[1];
  // Active bank follows the select pin as latched into bank_reg at run start.
  wire bank_now = bank_sync_reg[1];
  wire [31:0] active_bank = bank_reg ? bank_b_settings_reg : bank_a_settings_reg;
  wire [5:0] active_pump = bank_reg ? bank_b_pump_current_reg : bank_a_pump_current_reg;

  wire apb_access = psel & penable & ~ready_reg;
  wire apb_wr = apb_access & pwrite;
  wire hit_ctrl = paddr == PBC_OFF_CTRL;
  wire hit_a = paddr == PBC_OFF_BANK_A;
  wire hit_b = paddr == PBC_OFF_BANK_B;
  wire hit_pump = paddr == PBC_OFF_PUMP;
  wire hit_stat = paddr == PBC_OFF_STATUS;
  wire hit_cal = paddr == PBC_OFF_CAL;
  wire hit_any = hit_ctrl | hit_a | hit_b | hit_pump | hit_stat | hit_cal;
  wire warm_done = warm_reg == 8'h00;
  // A new run may start from idle or from a finished run.
  wire at_rest = (state_reg == PBC_IDLE) | (state_reg == PBC_DONE);
  wire relock_start = relock_reg & at_rest;
  // Enable edge only counts once the reference is warm.
  wire en_start = en_rise & warm_done & at_rest;
  wire run_start = relock_start | en_start;
  // Each search step waits a fixed settle count, so a run stays short.
  wire settled = settle_reg == 16'h0000;
  wire [31:0] rd_mux;

  // Divider select passes as is; code 0 stands for the top ratio of 32.
  function automatic logic [4:0] pbc_lodiv(input logic [4:0] sel);
    pbc_lodiv = sel;
  endfunction

  assign rd_mux =
    hit_ctrl ? {16'h0, ref_warmup_count_reg, 3'h0, aux_level_reg, aux_lock_reg, bwcal_reg,
                keepalive_reg, relock_reg} :
    hit_a ? bank_a_settings_reg :
    hit_b ? bank_b_settings_reg :
    hit_pump ? {20'h0, bank_b_pump_current_reg, bank_a_pump_current_reg} :
    // Read-back shows band code, failure flag and lock.
    hit_stat ? {16'h0, 1'b0, band_reg, vco_reg, 1'b0, state_reg,
                band_search_fail_flag_reg, lock_reg} :
    hit_cal ? {26'h0, out_pump_reg} : 32'h0;

  // One wait state: the answer is registered so every bus output leaves a flop.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ready_reg <= apb_access;
      err_reg <= apb_access & ~hit_any;
      if (apb_access & ~pwrite) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Pump fields reset to the default and are six bits wide.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bank_a_settings_reg <= {PBC_REFDIV_DEFAULT, 5'h01, 24'h0};
      bank_b_settings_reg <= {PBC_REFDIV_DEFAULT, 5'h01, 24'h0};
      bank_a_pump_current_reg <= PBC_CP_DEFAULT;
      bank_b_pump_current_reg <= PBC_CP_DEFAULT;
      keepalive_reg <= 1'b0;
      bwcal_reg <= 1'b0;
      aux_lock_reg <= 1'b1;
      aux_level_reg <= 1'b0;
      ref_warmup_count_reg <= PBC_WARM_DEFAULT;
    end else if (apb_wr) begin
      if (hit_ctrl) begin
        keepalive_reg <= pwdata[PBC_CTRL_KEEPALIVE];
        bwcal_reg <= pwdata[PBC_CTRL_BWCAL_EN];
        aux_lock_reg <= pwdata[PBC_CTRL_AUX_LOCK];
        aux_level_reg <= pwdata[PBC_CTRL_AUX_LEVEL];
        ref_warmup_count_reg <= pwdata[PBC_CTRL_WARM_LSB +: PBC_WARM_W];
      end else if (hit_a) begin
        bank_a_settings_reg <= pwdata;
      end else if (hit_b) begin
        bank_b_settings_reg <= pwdata;
      end else if (hit_pump) begin
        bank_a_pump_current_reg <= pwdata[5:0];
        bank_b_pump_current_reg <= pwdata[11:6];
      end
    end
  end

  // Re-lock bit sets on write and clears when the run begins.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      relock_reg <= 1'b0;
    end else if (apb_wr & hit_ctrl & pwdata[PBC_CTRL_RELOCK]) begin
      relock_reg <= 1'b1;
    end else if (relock_start) begin
      relock_reg <= 1'b0;
    end
  end

  // Warm-up reloads on cold start and on a keepalive clear.
  // Reference stays powered only when kept alive or in use.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warm_reg <= PBC_WARM_DEFAULT;
      ref_power_on <= 1'b0;
    end else begin
      ref_power_on <= keepalive_reg | en_now | (state_reg != PBC_IDLE) | relock_reg;
      if (apb_wr & hit_ctrl & ~pwdata[PBC_CTRL_KEEPALIVE] & keepalive_reg) begin
        warm_reg <= pwdata[PBC_CTRL_WARM_LSB +: PBC_WARM_W];
      end else if (~warm_done & (keepalive_reg | en_now)) begin
        // Count only while the reference is powered.
        warm_reg <= warm_reg - 8'h01;
      end
    end
  end

  // One step per detector clock; duration scales with that rate.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PBC_IDLE: begin
        if (run_start) begin
          state_next = PBC_VCO_PICK;
        end
      end
      PBC_VCO_PICK: begin
        if (settled & (~rng_fast | (vco_reg == PBC_VCO_COUNT - 2'h1))) begin
          state_next = PBC_BAND;
        end
      end
      PBC_BAND: begin
        if (settled & (steps_left_reg == 3'h0) & (step_reg == 7'h00)) begin
          state_next = PBC_PUMP;
        end
      end
      PBC_PUMP: begin
        state_next = PBC_LOCKING;
      end
      PBC_LOCKING: begin
        state_next = PBC_DONE;
      end
      PBC_DONE: begin
        if (run_start) begin
          state_next = PBC_VCO_PICK;
        end else if (~en_now & ~keepalive_reg) begin
          state_next = PBC_IDLE;
        end
      end
      default: begin
        state_next = PBC_IDLE;
      end
    endcase
  end

  wire done_idle_start = (state_reg == PBC_DONE) & (relock_reg | en_rise);

  // VCO walk then binary band search from the middle code.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= PBC_IDLE;
      vco_reg <= 2'h0;
      band_reg <= PBC_BAND_START;
      step_reg <= 7'h20;
      steps_left_reg <= PBC_BAND_STEPS;
      settle_reg <= 16'h0000;
      band_search_fail_flag_reg <= 1'b0;
      bank_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (settle_reg != 16'h0000) begin
        settle_reg <= settle_reg - 16'h0001;
      end
      if ((state_reg != PBC_VCO_PICK) && (state_next == PBC_VCO_PICK)) begin
        // Failure flag clears at run start.
        band_search_fail_flag_reg <= 1'b0;
        bank_reg <= bank_now;
        vco_reg <= 2'h0;
        band_reg <= PBC_BAND_START;
        step_reg <= 7'h20;
        steps_left_reg <= PBC_BAND_STEPS;
        settle_reg <= 16'(SETTLE_CYCLES);
      end else if ((state_reg == PBC_VCO_PICK) && settled && (state_next == PBC_VCO_PICK)) begin
        vco_reg <= vco_reg + 2'h1;
        settle_reg <= 16'(SETTLE_CYCLES);
      end else if ((state_reg == PBC_BAND) && settled) begin
        if (step_reg == 7'h00) begin
          band_reg <= cmp_fast ? band_reg - 7'h01 : band_reg;
        end else begin
          band_reg <= cmp_fast ? band_reg - step_reg : band_reg + step_reg;
        end
        step_reg <= step_reg >> 1;
        if (steps_left_reg != 3'h0) begin
          steps_left_reg <= steps_left_reg - 3'h1;
        end
        settle_reg <= 16'(SETTLE_CYCLES);
      end else if (state_reg == PBC_PUMP) begin
        // Edge codes mean failure, 1 to 126 success.
        band_search_fail_flag_reg <= (band_reg == PBC_BAND_LOW_FAIL) |
                                     (band_reg == PBC_BAND_HIGH_FAIL);
      end
    end
  end

  // Lock flag follows the tuning window once locking is allowed.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= lock_sync_reg[1] & (state_reg == PBC_DONE);
    end
  end

  // Pump current from measurement when calibration is enabled.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_pump_reg <= PBC_CP_DEFAULT;
      out_frac_reg <= 32'h0;
    end else begin
      if (state_reg == PBC_PUMP) begin
        out_pump_reg <= bwcal_reg ? measured_pump : active_pump;
      end else if (state_reg == PBC_IDLE) begin
        out_pump_reg <= active_pump;
      end
      // Divider words follow the bank latched at run start, not the live pin.
      out_frac_reg <= active_bank;
    end
  end

  // Divider words and loop enable leave from flops.
  // Aux output shows lock when so configured.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vco_select <= 2'h0;
      band_code <= '0;
      frac_word <= '0;
      local_osc_divider <= 5'h01;
      ref_divider <= PBC_REFDIV_DEFAULT;
      pump_current <= PBC_CP_DEFAULT;
      loop_enable <= 1'b0;
      aux_out_four <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      vco_select <= vco_reg;
      band_code <= BAND_W'(band_reg);
      frac_word <= out_frac_reg[PBC_FRAC_W-1:0];
      local_osc_divider <= pbc_lodiv(out_frac_reg[PBC_LODIV_LSB +: 5]);
      ref_divider <= out_frac_reg[PBC_REFDIV_LSB +: 3];
      pump_current <= out_pump_reg;
      loop_enable <= (state_reg == PBC_LOCKING) | (state_reg == PBC_DONE);
      aux_out_four <= aux_lock_reg ? lock_reg : aux_level_reg;
      prdata <= apb_access & ~pwrite ? rd_mux : 32'h0;
      pready <= apb_access;
      pslverr <= apb_access & ~hit_any;
    end
  end

  wire unused_ok = &{1'b0, done_idle_start, rdata_reg[0], ready_reg, err_reg};
endmodule

// ### logic/pbc_pkg.sv
// Package for the synthesizer calibration and control block.
// Assumes one 20 MHz clock domain and an APB register port.
package pbc_pkg;
  localparam logic [11:0] PBC_OFF_CTRL = 12'h000;
  localparam logic [11:0] PBC_OFF_BANK_A = 12'h004;
  localparam logic [11:0] PBC_OFF_BANK_B = 12'h008;
  localparam logic [11:0] PBC_OFF_PUMP = 12'h00c;
  localparam logic [11:0] PBC_OFF_STATUS = 12'h010;
  localparam logic [11:0] PBC_OFF_CAL = 12'h014;
  // Control register fields.
  localparam int PBC_CTRL_RELOCK = 0;
  localparam int PBC_CTRL_KEEPALIVE = 1;
  localparam int PBC_CTRL_BWCAL_EN = 2;
  localparam int PBC_CTRL_AUX_LOCK = 3;
  localparam int PBC_CTRL_AUX_LEVEL = 4;
  localparam int PBC_CTRL_WARM_LSB = 8;
  localparam int PBC_WARM_W = 8;
  // Bank register fields: frac 23:0, lo divider select 28:24, ref divider 31:29.
  localparam int PBC_FRAC_W = 24;
  localparam int PBC_LODIV_LSB = 24;
  localparam int PBC_REFDIV_LSB = 29;
  localparam int PBC_CP_W = 6;
  localparam logic [5:0] PBC_CP_DEFAULT = 6'h1f;
  localparam logic [5:0] PBC_CP_MAX = 6'h3f;
  localparam logic [6:0] PBC_BAND_LOW_FAIL = 7'h00;
  localparam logic [6:0] PBC_BAND_HIGH_FAIL = 7'h7f;
  localparam logic [6:0] PBC_BAND_START = 7'h40;
  localparam logic [1:0] PBC_VCO_COUNT = 2'h3;
  localparam logic [7:0] PBC_WARM_DEFAULT = 8'h10;
  localparam logic [2:0] PBC_REFDIV_DEFAULT = 3'h1;
  // Band search walks six halving steps from the middle code.
  localparam logic [2:0] PBC_BAND_STEPS = 3'h6;
  localparam int PBC_CLK_MHZ = 20;
  localparam int PBC_SETTLE_NS = 400;
  localparam int PBC_SETTLE_CYC = (PBC_SETTLE_NS * PBC_CLK_MHZ) / 1000;
  typedef enum logic [2:0] {
    PBC_IDLE = 3'b000,
    PBC_VCO_PICK = 3'b001,
    PBC_BAND = 3'b011,
    PBC_PUMP = 3'b010,
    PBC_LOCKING = 3'b110,
    PBC_DONE = 3'b111
  } pbc_state_t;
endpackage

// ### verification/pbc_core_assertions.sv
// Port checker for the synthesizer calibration block.
// Assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/1ps
module pbc_core_checker import pbc_pkg::*; #(
  parameter int BAND_W = 7
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hard_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] vco_select,
  input wire logic [BAND_W-1:0] band_code,
  input wire logic [4:0] local_osc_divider,
  input wire logic [2:0] ref_divider,
  input wire logic [PBC_CP_W-1:0] pump_current,
  input wire logic loop_enable,
  input wire logic aux_out_four
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire rst_vals = pump_current == PBC_CP_DEFAULT && local_osc_divider == 5'h01
    && ref_divider == 3'h1 && !loop_enable && band_code == '0;
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  AST_ANSWER: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  AST_IDLE_QUIET: assert property (!psel |=> !pready)
    else $error("pready without a request");
  AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access with data or without pready");
  AST_SYS_RST: assert property ($fell(sys_rst) |-> rst_vals)
    else $error("outputs not at startup values after reset");
  AST_PIN_RST: assert property (!hard_reset_n [*4] |=> rst_vals)
    else $error("reset pin did not restore startup values");
  AST_BAND_HELD: assert property (loop_enable && $past(loop_enable) |->
    $stable(band_code) && $stable(vco_select))
    else $error("band choice moved while locking");
  AST_AUX_LOCK: assert property (aux_out_four |-> loop_enable || $past(loop_enable))
    else $error("lock shown outside locking");
  cover property (pslverr);
  cover property ($rose(loop_enable));
  cover property ($rose(aux_out_four));
endmodule
bind pbc_core pbc_core_checker #(.BAND_W(BAND_W)) pbc_core_checker_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .hard_reset_n(hard_reset_n),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .vco_select(vco_select), .band_code(band_code),
  .local_osc_divider(local_osc_divider), .ref_divider(ref_divider),
  .pump_current(pump_current), .loop_enable(loop_enable), .aux_out_four(aux_out_four));

// ### verification/pbc_loop_model.sv
// Behavioural model of the analog loop beside the control block.
// Assumes the bench sets the target VCO, target band and window level.
`timescale 1ns/1ps
module pbc_loop_model (
  input wire logic ref_clk,
  input wire logic [1:0] vco_select,
  input wire logic [6:0] band_code,
  input wire logic loop_enable,
  input wire logic [1:0] tgt_vco,
  input wire logic [7:0] tgt_band,
  input wire logic win_ok,
  output logic [1:0] vco_too_fast,
  output logic tune_in_window
);
  initial begin
    vco_too_fast = 2'h0;
    tune_in_window = 1'b0;
  end
  always @(posedge ref_clk) begin
    vco_too_fast[1] <= vco_select < tgt_vco;
    vco_too_fast[0] <= {1'b0, band_code} > tgt_band;
    tune_in_window <= loop_enable && win_ok;
  end
endmodule

// ### verification/pbc_core_tb_top.sv
// Self-checking bench for the synthesizer calibration block.
// Assumes the loop model stands in for the analog side.
`timescale 1ns/1ps
module pbc_core_tb_top import pbc_pkg::*; ;
  logic ref_clk, sys_rst, hard_reset_n, enable_pin, bank_select, win_ok;
  logic psel, penable, pwrite, pready, pslverr, loop_enable, aux_out_four;
  logic ref_power_on, tune_in_window, rerr;
  logic [1:0] vco_too_fast, vco_select, tgt_vco;
  logic [5:0] measured_pump, pump_current;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, seed, bank_a, bank_b, pumps;
  logic [6:0] band_code;
  logic [7:0] tgt_band;
  logic [23:0] frac_word;
  logic [4:0] local_osc_divider;
  logic [2:0] ref_divider;
  int error_cnt = 0;
  int tests_run = 0;
  pbc_core pbc_core_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .hard_reset_n(hard_reset_n),
    .enable_pin(enable_pin), .bank_select(bank_select), .vco_too_fast(vco_too_fast),
    .tune_in_window(tune_in_window), .measured_pump(measured_pump), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vco_select(vco_select), .band_code(band_code),
    .frac_word(frac_word), .local_osc_divider(local_osc_divider), .ref_divider(ref_divider),
    .pump_current(pump_current), .ref_power_on(ref_power_on), .loop_enable(loop_enable),
    .aux_out_four(aux_out_four));
  pbc_loop_model pbc_loop_model_inst (.ref_clk(ref_clk), .vco_select(vco_select),
    .band_code(band_code), .loop_enable(loop_enable), .tgt_vco(tgt_vco),
    .tgt_band(tgt_band), .win_ok(win_ok), .vco_too_fast(vco_too_fast),
    .tune_in_window(tune_in_window));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] near(input logic [6:0] b, input logic [7:0] t);
    return {31'h0, ({1'b0, b} + 8'h01 >= t) && ({1'b0, b} <= t + 8'h01)};
  endfunction
  task automatic end_of_test();
    $display("Checks made %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_check(input logic bw);
    logic [31:0] bk;
    logic edge_cut;
    int n;
    n = 0;
    do begin
      apb(1'b0, PBC_OFF_STATUS, 32'h0);
      n++;
    end while (rdat[4:2] !== PBC_DONE && n < 80);
    if (rdat[4:2] !== PBC_DONE) begin
      error_cnt++;
      end_of_test();
    end
    repeat (6) @(posedge ref_clk);
    apb(1'b0, PBC_OFF_STATUS, 32'h0);
    bk = bank_select ? bank_b : bank_a;
    chk("vco", {30'h0, tgt_vco}, {30'h0, vco_select});
    edge_cut = (tgt_band == 8'hff) || (tgt_band == 8'h00);
    if (edge_cut)
      chk("band edge", {25'h0, tgt_band[6:0]}, {25'h0, rdat[14:8]});
    else
      chk("band near", 32'h1, near(rdat[14:8], tgt_band));
    chk("fail", {31'h0, edge_cut}, {31'h0, rdat[1]});
    chk("loop", 32'h1, {31'h0, loop_enable});
    chk("ref on", 32'h1, {31'h0, ref_power_on});
    chk("lock", {31'h0, win_ok}, {31'h0, rdat[0]});
    chk("aux", {31'h0, win_ok}, {31'h0, aux_out_four});
    chk("frac", {8'h0, bk[23:0]}, {8'h0, frac_word});
    chk("lodiv", {27'h0, bk[28:24]}, {27'h0, local_osc_divider});
    chk("refdiv", {29'h0, bk[31:29]}, {29'h0, ref_divider});
    bk = bw ? {26'h0, measured_pump} : {26'h0, bank_select ? pumps[11:6] : pumps[5:0]};
    chk("pump", bk, {26'h0, pump_current});
    apb(1'b0, PBC_OFF_CTRL, 32'h0);
    chk("relock clear", 32'h0, {31'h0, rdat[0]});
  endtask
  initial begin
    {sys_rst, hard_reset_n, enable_pin, bank_select, win_ok} = 5'b11001;
    {psel, penable, pwrite, paddr, pwdata, measured_pump} = '0;
    seed = 32'h99d1;
    tgt_vco = 2'h0;
    tgt_band = 8'h40;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, PBC_OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h1008, rdat);
    apb(1'b0, PBC_OFF_PUMP, 32'h0);
    chk("pump reset", 32'h7df, rdat);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    enable_pin <= 1'b1;
    apb(1'b0, PBC_OFF_STATUS, 32'h0);
    apb(1'b0, PBC_OFF_STATUS, 32'h0);
    chk("cold wait", {29'h0, PBC_IDLE}, {29'h0, rdat[4:2]});
    enable_pin <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      seed = xs(seed);
      // Reference divider kept in 1 to 7.
      bank_a = {3'(seed[2:0] % 7 + 1), seed[28:0]};
      seed = xs(seed);
      bank_b = {3'(seed[2:0] % 7 + 1), seed[28:0]};
      seed = xs(seed);
      pumps = seed;
      bank_select <= seed[12];
      measured_pump <= seed[18:13];
      tgt_vco <= 2'(seed[20:19] % 3);
      tgt_band <= i == 1 ? 8'hff : i == 6 ? 8'h00 : {1'b0, 7'(seed[27:21] % 124 + 2)};
      win_ok <= i != 5;
      apb(1'b1, PBC_OFF_BANK_A, bank_a);
      apb(1'b1, PBC_OFF_BANK_B, bank_b);
      apb(1'b1, PBC_OFF_PUMP, {20'h0, pumps[11:0]});
      // Retrigger after every reprogramming, by pin or by write.
      apb(1'b1, PBC_OFF_CTRL, {16'h0, 16'h100a | {13'h0, i == 2, 2'h0} | {15'h0, i != 4}});
      if (i == 4) begin
        enable_pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
      end
      run_check(i == 2);
      enable_pin <= 1'b0;
    end
    apb(1'b1, PBC_OFF_CTRL, 32'h100b);
    repeat (10) @(posedge ref_clk);
    hard_reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    hard_reset_n <= 1'b1;
    chk("pin reset loop", 32'h0, {31'h0, loop_enable});
    apb(1'b0, PBC_OFF_CTRL, 32'h0);
    chk("pin reset ctrl", 32'h1008, rdat);
    chk("ref off", 32'h0, {31'h0, ref_power_on});
    end_of_test();
  end
endmodule
